//--- include/bsf_pkg.sv
// Purpose: Shared constants and carrier types of the buck start-up supervisor
// Assumes: clk_sys at 50 MHz, oscillator at its 200 kHz default
// Notes:   All timing is derived here from times in their own units

package bsf_pkg;

  // ==========================================================
  // Timing
  localparam int SYS_PERIOD_NS = 20;
  localparam int OSC_PERIOD_NS = 5000;
  localparam int OSC_DIV = OSC_PERIOD_NS / SYS_PERIOD_NS;
  // Phase-lock realign delay, a least time
  localparam int SYNC_DELAY_NS = 200;
  localparam int SYNC_DELAY = (SYNC_DELAY_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // Shortest accepted lock period: local frequency plus 40 percent
  localparam int SYNC_MIN_PER = (OSC_DIV * 100 + 139) / 140;
  // Ultrasonic timer, a longest time, so it rounds down
  localparam int ULTRA_NS = 30000;
  localparam int ULTRA_CYC = ULTRA_NS / SYS_PERIOD_NS;
  // Counts in oscillator cycles
  localparam int SS_WAIT_OSC = 16;
  localparam int SS_RAMP_OSC = 1024;
  localparam int UV_EN_PCT = 80;
  localparam int UV_EN_REF = SS_RAMP_OSC * UV_EN_PCT / 100;
  localparam int PG_DLY_OSC = 3;
  localparam int UV_RETRY_OSC = 64;
  localparam int OC_SLOW_CNT = 4;

  // ==========================================================
  // Register map
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_REF = 4'h8;
  localparam int CTRL_SYNC_BIT = 0;
  localparam int CTRL_DCM_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam int STAT_ST_LSB = 0;
  localparam int STAT_FLT_LSB = 3;
  localparam int STAT_PG_BIT = 8;
  localparam int STAT_LK_BIT = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_WAIT = 3'h1,
    ST_RAMP = 3'h2,
    ST_PGDLY = 3'h3,
    ST_RUN = 3'h4,
    ST_RETRY = 3'h5
  } bsf_state_e;

  // Comparator flags from the analog front end, all asynchronous
  typedef struct packed {
    logic core_ok;
    logic drv_ok;
    logic en_low;
    logic ov;
    logic below_half;
    logic uv;
    logic win_ok;
    logic pre_ov;
    logic oc_slow;
    logic oc_fast;
    logic zc_neg;
    logic hg_req;
    logic lock_in;
  } bsf_sense_s;

  typedef struct packed {
    logic ov;
    logic bleed;
    logic uv;
    logic ocs;
    logic ocf;
  } bsf_fault_s;

endpackage

//--- rtl/bsf_sync.sv
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels
// Assumes: Each bit is an independent level
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module bsf_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bsf_sync_s;

  bsf_sync_s r;
  bsf_sync_s n;

  // ==========================================================
  // Stages
  always_comb begin
    n.s1 = d;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.s2;

endmodule
`default_nettype wire

//--- rtl/bsf_osc.sv
// Purpose: Switching oscillator tick with phase lock to an external edge
// Assumes: lock_in is already synchronised to clk_sys
// Notes:   A lock edge outside the frequency window is not followed
`timescale 1ns/1ps
`default_nettype none

module bsf_osc
  import bsf_pkg::*;
#(
  parameter int DIV = OSC_DIV,
  parameter int DLY = SYNC_DELAY,
  parameter int MINP = SYNC_MIN_PER
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control and lock input
  input wire logic sync_en,
  input wire logic lock_in,
  // Results
  output logic tick,
  output logic locked
);

  localparam int CW = $clog2(DIV);
  localparam int PW = $clog2(DIV + 2);
  localparam int DW = $clog2(DLY + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [PW-1:0] per;
    logic [DW-1:0] dcnt;
    logic prev;
    logic pend;
    logic locked;
    logic tick;
  } bsf_osc_s;

  bsf_osc_s r;
  bsf_osc_s n;
  logic fall;
  logic in_rng;

  // ==========================================================
  // Free-running divider, realigned after each in-range falling edge
  always_comb begin
    n = r;
    n.tick = 1'b0;
    n.prev = lock_in;
    fall = r.prev && !lock_in;
    in_rng = (r.per >= PW'(MINP)) && (r.per <= PW'(DIV));
    // Period meter saturates so a stopped input reads out of range
    if (r.per != PW'(DIV + 1)) begin
      n.per = r.per + 1'b1;
    end
    if (r.cnt == CW'(DIV - 1)) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + 1'b1;
    end
    if (fall) begin
      n.per = '0;
      n.locked = sync_en && in_rng; // R9
      if (sync_en && in_rng) begin
        n.pend = 1'b1;
        n.dcnt = '0;
      end
    end else if (!sync_en) begin
      n.locked = 1'b0;
    end
    // Fixed delay after the edge, then restart the ramp phase
    if (r.pend && !fall) begin
      if (r.dcnt == DW'(DLY - 1)) begin
        n.pend = 1'b0;
        n.cnt = '0; // R8 R22
        n.tick = 1'b1;
      end else begin
        n.dcnt = r.dcnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;
  assign locked = r.locked;

endmodule
`default_nettype wire

//--- rtl/bsf_top.sv
// Purpose: Start-up sequencing and fault supervision of a buck controller
// Assumes: Comparator flags arrive asynchronously; gate drivers add dead time
// Notes:   Registers over AXI4-Lite: control, status, soft-start reference
// Behaviour
// R1 - Enable pin pulled low disables switching
// R2 - Start only with both supplies up, enabled
// R3 - Wait, then ramp reference over 1024 cycles
// R4 - Release output-ok 3 cycles after ramp
// R5 - Overvoltage protection always active in soft-start
// R6 - Undervoltage ignored below 80 percent reference
// R7 - Soft-start undervoltage restarts after fixed delay
// R8 - Realign ramp phase after lock falling edge
// R9 - Lock input within 0-40 percent above
// R10 - Output-ok low in soft-start and faults; the overcurrent latches do not pull it low
// R11 - Overvoltage latches, low gate on, then bleed
// R12 - Overvoltage cleared only by supply or enable
// R13 - Run-time undervoltage latches, both gates off
// R14 - Undervoltage cleared only by supply or enable
// R15 - Disabled overvoltage guard drives low gate
// R16 - Four slow overcurrent cycles latch, gates off
// R17 - Fast overcurrent latches at once, gates off
// R18 - Overcurrent cleared only by supply or enable
// R19 - Zero-current detect turns low gate off
// R20 - Ultrasonic timer restarts on every high pulse
// R21 - Timer expiry forces low gate on
// R22 - Light load interleaves with in-range lock
// R23 - Gates never both on; faults override
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module bsf_top
  import bsf_pkg::*;
#(
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Analog comparator flags
  input wire bsf_sense_s sense_in,
  // Power stage
  output logic high_gate,
  output logic low_gate,
  output logic bleed_switch,
  output logic [9:0] ss_ref,
  // Open-drain output-ok pin
  output logic output_ok_out,
  output logic output_ok_oe,
  // AXI4-Lite write
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    bsf_state_e st;
    logic [9:0] ref_lvl;
    logic [7:0] dly;
    bsf_fault_s flt;
    logic [1:0] oc_cnt;
    logic [10:0] ut;
    logic ut_exp;
    logic zc_off;
    logic hg;
    logic lg;
    logic hs;
    logic pg_pull;
    logic [1:0] ctrl;
    logic aw_ok;
    logic [AW-1:0] aw_a;
    logic w_ok;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bv;
    logic [1:0] bresp;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rresp;
  } bsf_top_s;

  bsf_top_s r;
  bsf_top_s n;
  bsf_sense_s s;
  logic tick;
  logic locked;
  logic armed;
  logic uv_en;
  logic sw_on;
  logic want_h;
  logic want_l;
  logic h;
  logic l;
  logic [1:0] wsel;
  logic [1:0] rsel;

  // ==========================================================
  // Input synchroniser and oscillator
  bsf_sync #(.W($bits(bsf_sense_s))) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(sense_in),
    .q(s)
  );

  bsf_osc u_osc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sync_en(r.ctrl[CTRL_SYNC_BIT]),
    .lock_in(s.lock_in),
    .tick(tick),
    .locked(locked)
  );

  // ==========================================================
  // Register decode, shared by the read and write paths
  function automatic logic [1:0] reg_sel(input logic [AW-1:0] a);
    logic [3:0] w;
    w = 4'({a[AW-1:2], 2'b00});
    case (w)
      ADDR_CTRL: reg_sel = 2'd0;
      ADDR_STATUS: reg_sel = 2'd1;
      ADDR_REF: reg_sel = 2'd2;
      default: reg_sel = 2'd3;
    endcase
  endfunction

  // ==========================================================
  // Sequencer, protection and bus slave
  always_comb begin
    n = r;
    armed = s.core_ok && !s.en_low; // R1
    uv_en = r.ref_lvl >= 10'(UV_EN_REF);
    sw_on = (r.st == ST_RAMP) || (r.st == ST_PGDLY) || (r.st == ST_RUN);
    wsel = 2'd3;
    rsel = 2'd3;

    // Sequencer; losing core supply or enable clears every latch
    if (!armed) begin
      n.st = ST_OFF;
      n.flt = '0; // R12 R14 R18
      n.oc_cnt = '0;
      n.ref_lvl = '0;
    end else if (!s.drv_ok) begin
      n.st = ST_OFF;
      n.ref_lvl = '0;
    end else begin
      case (r.st)
        ST_OFF: begin
          n.st = ST_WAIT; // R2
          n.dly = '0;
        end
        ST_WAIT: begin
          if (tick) begin
            n.dly = r.dly + 1'b1;
            if (r.dly == 8'(SS_WAIT_OSC - 1)) begin
              n.st = ST_RAMP;
              n.ref_lvl = '0;
            end
          end
        end
        ST_RAMP: begin
          if (uv_en && s.uv) begin
            n.st = ST_RETRY; // R6 R7
            n.dly = '0;
            n.ref_lvl = '0;
          end else if (tick) begin
            if (r.ref_lvl == 10'(SS_RAMP_OSC - 1)) begin
              n.st = ST_PGDLY;
              n.dly = '0;
            end else begin
              n.ref_lvl = r.ref_lvl + 1'b1; // R3
            end
          end
        end
        ST_PGDLY: begin
          if (s.uv) begin
            n.st = ST_RETRY; // R7
            n.dly = '0;
            n.ref_lvl = '0;
          end else if (tick) begin
            n.dly = r.dly + 1'b1;
            if (r.dly == 8'(PG_DLY_OSC - 1)) begin
              n.st = ST_RUN; // R4
            end
          end
        end
        ST_RUN: begin
          if (s.uv) begin
            n.flt.uv = 1'b1; // R13
          end
        end
        ST_RETRY: begin
          if (tick) begin
            n.dly = r.dly + 1'b1;
            if (r.dly == 8'(UV_RETRY_OSC - 1)) begin
              n.st = ST_WAIT;
              n.dly = '0;
            end
          end
        end
        default: begin
          n.st = ST_OFF;
        end
      endcase
    end

    // Protection latches, independent of ramp progress
    if (armed) begin
      if (s.ov) begin
        n.flt.ov = 1'b1; // R5 R11
      end
      if (r.flt.ov && s.below_half) begin
        n.flt.bleed = 1'b1; // R11
      end
      if (s.oc_fast) begin
        n.flt.ocf = 1'b1; // R17
      end
      // Slow trip counts whole switching cycles, fast level excluded
      if (tick) begin
        if (s.oc_slow && !s.oc_fast) begin
          if (r.oc_cnt == 2'(OC_SLOW_CNT - 1)) begin
            n.flt.ocs = 1'b1; // R16
          end else begin
            n.oc_cnt = r.oc_cnt + 1'b1;
          end
        end else begin
          n.oc_cnt = '0;
        end
      end
    end

    // Ultrasonic timer runs while the high gate is off
    if (r.hg) begin
      n.ut = '0; // R20
      n.ut_exp = 1'b0;
      n.zc_off = 1'b0;
    end else begin
      if (r.ut == 11'(ULTRA_CYC - 1)) begin
        n.ut_exp = 1'b1;
      end else if (!r.ut_exp) begin
        n.ut = r.ut + 1'b1;
      end
      if (r.lg && s.zc_neg && r.ctrl[CTRL_DCM_BIT]) begin
        n.zc_off = 1'b1; // R19
      end
    end

    // Normal switching: a pulse starts only on an oscillator tick
    want_h = sw_on && s.hg_req && (r.hg || tick || r.hs);
    want_l = sw_on && !want_h && (!n.zc_off || n.ut_exp); // R19 R21

    // Fault overrides win over the switching request
    if (!armed) begin
      want_h = 1'b0;
      want_l = s.core_ok && s.drv_ok && s.pre_ov; // R15
    end else if (!s.drv_ok || n.flt.uv || n.flt.ocs || n.flt.ocf) begin
      want_h = 1'b0; // R13 R16 R17 R23
      want_l = 1'b0;
    end else if (n.flt.ov) begin
      want_h = 1'b0; // R11 R23
      want_l = !n.flt.bleed;
    end

    // One dead cycle on every hand-over between gates
    h = want_h && !r.lg;
    l = want_l && !h && !r.hg; // R23
    n.hg = h;
    n.lg = l;
    n.hs = want_h && !h; // Tick start waits out the dead cycle
    n.pg_pull = (n.st != ST_RUN) || n.flt.ov || n.flt.uv || !s.win_ok; // R10

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && !r.aw_ok && !r.bv) begin
      n.aw_ok = 1'b1;
      n.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_ok && !r.bv) begin
      n.w_ok = 1'b1;
      n.w_d = s_axi_wdata;
      n.w_s = s_axi_wstrb;
    end
    if (n.aw_ok && n.w_ok && !r.bv) begin
      wsel = reg_sel(n.aw_a);
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bv = 1'b1;
      n.bresp = (wsel == 2'd3) ? RESP_SLVERR : RESP_OKAY;
      if (wsel == 2'd0 && n.w_s[0]) begin
        n.ctrl = n.w_d[1:0];
      end
    end else if (r.bv && s_axi_bready) begin
      n.bv = 1'b0;
    end

    // Read channel: data the cycle after the address
    if (s_axi_arvalid && !r.rv) begin
      rsel = reg_sel(s_axi_araddr);
      n.rv = 1'b1;
      n.rd = '0;
      n.rresp = RESP_OKAY;
      case (rsel)
        2'd0: n.rd[1:0] = r.ctrl;
        2'd1: begin
          n.rd[STAT_ST_LSB +: 3] = r.st;
          n.rd[STAT_FLT_LSB +: 5] = r.flt;
          n.rd[STAT_PG_BIT] = !r.pg_pull;
          n.rd[STAT_LK_BIT] = locked;
        end
        2'd2: n.rd[9:0] = r.ref_lvl;
        default: n.rresp = RESP_SLVERR;
      endcase
    end else if (r.rv && s_axi_rready) begin
      n.rv = 1'b0;
    end
  end

  // State register, pulls output-ok low from reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= ST_OFF;
      r.pg_pull <= 1'b1;
      r.ctrl <= CTRL_RST;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign high_gate = r.hg;
  assign low_gate = r.lg;
  assign bleed_switch = r.flt.bleed;
  assign ss_ref = r.ref_lvl;
  assign output_ok_out = 1'b0;
  assign output_ok_oe = r.pg_pull;
  assign s_axi_awready = !r.aw_ok && !r.bv;
  assign s_axi_wready = !r.w_ok && !r.bv;
  assign s_axi_bvalid = r.bv;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rv;
  assign s_axi_rvalid = r.rv;
  assign s_axi_rdata = r.rd;
  assign s_axi_rresp = r.rresp;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_live;
    s.core_ok && !s.en_low && s.drv_ok;
  endsequence

  property p_no_overlap;
    !(high_gate && low_gate);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("gates overlap"); // R23

  property p_fast_trip;
    (s_live ##0 s.oc_fast) |=> r.flt.ocf && !high_gate && !low_gate;
  endproperty
  a_fast_trip: assert property (p_fast_trip) else $error("fast trip missed"); // R17

  property p_ov_latch;
    (s_live ##0 s.ov) |=> r.flt.ov && !high_gate;
  endproperty
  a_ov_latch: assert property (p_ov_latch) else $error("overvoltage missed"); // R11

  property p_ov_hold;
    (r.flt.ov ##1 s_live) |-> r.flt.ov;
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("overvoltage cleared"); // R12

  property p_pg_low;
    (r.st != ST_RUN || r.flt.ov || r.flt.uv) |-> output_ok_oe;
  endproperty
  a_pg_low: assert property (p_pg_low) else $error("output ok released"); // R10

  property p_uv_ignore;
    (s_live ##0 (r.st == ST_RAMP && !uv_en && !tick)) |=> r.st == ST_RAMP;
  endproperty
  a_uv_ignore: assert property (p_uv_ignore) else $error("early undervoltage"); // R6

  property p_uv_restart;
    (s_live ##0 (r.st == ST_RAMP && uv_en && s.uv)) |=> r.st == ST_RETRY && !r.flt.uv;
  endproperty
  a_uv_restart: assert property (p_uv_restart) else $error("no restart"); // R7

  property p_oc_slow;
    $rose(r.flt.ocs) |-> $past(r.oc_cnt) == 2'(OC_SLOW_CNT - 1);
  endproperty
  a_oc_slow: assert property (p_oc_slow) else $error("slow trip count"); // R16

  property p_pre_ov;
    (s.core_ok && s.en_low && s.drv_ok && s.pre_ov && !high_gate) |=> low_gate;
  endproperty
  a_pre_ov: assert property (p_pre_ov) else $error("guard inactive"); // R15

endmodule
`default_nettype wire

//--- dv/bsf_stage_model.sv
// Purpose: Far-side model: sense network, enable pin and phase-lock source
// Assumes: Levels come from the bench in percent of reference, millivolts and ohms
// Notes:   Ideal comparators, no hysteresis; lock source stands low when off
`timescale 1ns/1ps
`default_nettype none

module bsf_stage_model
  import bsf_pkg::*;
#(
  parameter int PRE_OV_PCT = 110
) (
  // Clock
  input wire logic clk_sys,
  // Levels set by the bench
  input wire logic supply_core,
  input wire logic supply_drv,
  input var int en_ohms,
  input var int vs_pct,
  input var int cs_mv,
  input wire logic zc,
  input wire logic hg,
  input var int lock_per,
  // Comparator flags
  output var bsf_sense_s sense
);
  // ==========================================================
  // Lock source
  logic lock_r = 1'b0;
  int cnt_r = 0;

  // Square wave of lock_per cycles; the bench drives it both inside and outside the lock window
  always @(posedge clk_sys) begin
    if (lock_per == 0) begin
      lock_r <= 1'b0;
      cnt_r <= 0;
    end else if (cnt_r >= lock_per / 2 - 1) begin
      lock_r <= ~lock_r;
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end

  // ==========================================================
  // Comparators of the sense network
  always_comb begin
    sense.core_ok = supply_core;
    sense.drv_ok = supply_drv;
    sense.en_low = en_ohms < 10000;
    sense.ov = vs_pct > 125;
    sense.below_half = vs_pct < 50;
    sense.uv = vs_pct < 75;
    sense.win_ok = vs_pct >= 90 && vs_pct <= 110;
    sense.pre_ov = vs_pct > PRE_OV_PCT;
    sense.oc_slow = cs_mv > 20;
    sense.oc_fast = cs_mv > 30;
    sense.zc_neg = zc;
    sense.hg_req = hg;
    sense.lock_in = lock_r;
  end
endmodule
`default_nettype wire

//--- dv/buck_startup_fault_supervisor_tb.sv
// Purpose: Self-checking bench of the start-up and fault supervisor
// Assumes: Oscillator divider at its fixed default, 250 clocks a tick
// Notes:   Full ramp to run state is too long to simulate; ramp checks only
`timescale 1ns/1ps
`default_nettype none

module buck_startup_fault_supervisor_tb;
  import bsf_pkg::*;
  localparam int OPEN = 1000000;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic core = 1'b1, drv = 1'b1, zc = 1'b0, hg = 1'b0;
  int ohms = 0, pct = 100, mv = 0, lper = 0;
  bsf_sense_s sense;
  logic high_gate, low_gate, bleed_switch, ok_out, ok_oe;
  logic [9:0] ss_ref;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  int n_mismatch = 0, tests_run = 0, el, k;

  // ==========================================================
  // Clock, partner and design
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  bsf_stage_model stage_u (.clk_sys(clk_sys), .supply_core(core), .supply_drv(drv), .en_ohms(ohms),
    .vs_pct(pct), .cs_mv(mv), .zc(zc), .hg(hg), .lock_per(lper), .sense(sense));

  bsf_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .sense_in(sense), .high_gate(high_gate),
    .low_gate(low_gate), .bleed_switch(bleed_switch), .ss_ref(ss_ref), .output_ok_out(ok_out),
    .output_ok_oe(ok_oe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ==========================================================
  // Checking and closing
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tmo(input string nm);
    n_mismatch++;
    $display("wrong value %s expected answer seen timeout", nm);
    end_sim();
  endtask

  // Shoot-through is never allowed, whatever the scenario
  always @(negedge clk_sys) begin
    if (high_gate === 1'b1 && low_gate === 1'b1) check("gate_overlap", 1'b1, 1'b0);
  end

  // ==========================================================
  // Waits; sampling on the falling edge keeps clear of launch races
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wait_on(input int sel, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(negedge clk_sys);
      if (sel == 0 && ss_ref != 10'h0) return;
      if (sel == 1 && high_gate === 1'b1) return;
      if (sel == 2 && low_gate === 1'b1) return;
    end
    tmo("wait");
  endtask

  // ==========================================================
  // Register bus master
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      rs = bresp;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        return;
      end
    end
    tmo("axi_write");
  endtask

  task automatic axi_rd(input logic [3:0] a);
    logic ta, tr;
    int n;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk_sys);
      ta = arvalid && arready;
      tr = rvalid && rready;
      rd = rdata;
      rs = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        return;
      end
    end
    tmo("axi_read");
  endtask

  // Enable pin pulled low then released: clears latches and restarts
  task automatic restart;
    @(posedge clk_sys);
    ohms <= $urandom_range(9999);
    cyc(10);
    @(posedge clk_sys);
    ohms <= OPEN;
    wait_on(0, 20 * OSC_DIV, el);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(46841));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    axi_rd(ADDR_CTRL);
    check("ctrl_reset", rd, 32'(CTRL_RST));
    axi_wr(4'hc, 32'h1);
    check("bresp_unmapped", rs, RESP_SLVERR);
    axi_rd(4'hc);
    check("rresp_unmapped", rs, RESP_SLVERR);
    check("rdata_unmapped", rd, 32'h0);
    k = $urandom_range(3);
    axi_wr(ADDR_CTRL, 32'(k));
    axi_rd(ADDR_CTRL);
    check("ctrl_rw", rd, 32'(k));
    axi_wr(ADDR_CTRL, 32'(CTRL_RST));
    axi_wr(ADDR_STATUS, 32'hffff_ffff);
    check("bresp_status", rs, RESP_OKAY);
    $display("test registers done");
    // Disabled: guard on sense, no switching
    @(posedge clk_sys);
    pct <= 115;
    hg <= 1'b1;
    cyc(2 * OSC_DIV);
    check("guard_low", low_gate, 1'b1);
    check("disabled_high", high_gate, 1'b0);
    @(posedge clk_sys);
    pct <= 100;
    hg <= 1'b0;
    cyc(6);
    check("guard_off", low_gate, 1'b0);
    $display("test disabled done");
    // Driver supply low holds start-up off
    @(posedge clk_sys);
    drv <= 1'b0;
    ohms <= OPEN;
    cyc(300);
    axi_rd(ADDR_STATUS);
    check("state_nodrv", rd[2:0], ST_OFF);
    @(posedge clk_sys);
    drv <= 1'b1;
    wait_on(0, 20 * OSC_DIV, el);
    check("ss_wait", el >= 15 * OSC_DIV && el <= 18 * OSC_DIV + 10, 1'b1);
    k = ss_ref;
    cyc(OSC_DIV);
    check("ramp_step", ss_ref, 10'(k + 1));
    axi_rd(ADDR_STATUS);
    check("state_ramp", rd[2:0], ST_RAMP);
    check("pg_in_ramp", ok_oe, 1'b1);
    $display("test start done");
    // Undervoltage early in the ramp is ignored
    @(posedge clk_sys);
    pct <= 60;
    cyc(3 * OSC_DIV);
    axi_rd(ADDR_STATUS);
    check("uv_ignored", rd[2:0], ST_RAMP);
    check("uv_no_latch", rd[STAT_FLT_LSB + 2], 1'b0);
    // Light load: zero current, then ultrasonic expiry
    @(posedge clk_sys);
    pct <= 100;
    hg <= 1'b1;
    wait_on(1, 2 * OSC_DIV, el);
    @(posedge clk_sys);
    hg <= 1'b0;
    wait_on(2, 20, el);
    @(posedge clk_sys);
    zc <= 1'b1;
    cyc(5);
    check("zc_low_off", low_gate, 1'b0);
    @(posedge clk_sys);
    zc <= 1'b0;
    cyc(ULTRA_CYC - 200);
    check("ultra_early", low_gate, 1'b0);
    wait_on(2, 400, el);
    check("ultra_force", low_gate, 1'b1);
    $display("test light load done");
    // Overvoltage in soft-start: latch, low on, then bleed
    @(posedge clk_sys);
    pct <= 130;
    cyc(6);
    check("ov_gates", {high_gate, low_gate, bleed_switch}, 3'b010);
    @(posedge clk_sys);
    pct <= 40;
    cyc(6);
    check("ov_bleed", {high_gate, low_gate, bleed_switch}, 3'b001);
    @(posedge clk_sys);
    pct <= 100;
    cyc(50);
    axi_rd(ADDR_STATUS);
    check("ov_held", rd[STAT_FLT_LSB + 4], 1'b1);
    check("pg_ov", ok_oe, 1'b1);
    restart();
    axi_rd(ADDR_STATUS);
    check("ov_clear", rd[STAT_FLT_LSB + 4 -: 5], 5'h0);
    $display("test overvoltage done");
    // Fast overcurrent latches at once
    @(posedge clk_sys);
    mv <= 35;
    cyc(5);
    check("ocf_gates", {high_gate, low_gate}, 2'b00);
    @(posedge clk_sys);
    mv <= 0;
    cyc(20);
    axi_rd(ADDR_STATUS);
    check("ocf_held", rd[STAT_FLT_LSB], 1'b1);
    restart();
    // Slow overcurrent: short bursts pass, four ticks latch
    k = $urandom_range(3, 1);
    @(posedge clk_sys);
    mv <= 25;
    cyc(k * OSC_DIV - 3);
    @(posedge clk_sys);
    mv <= 0;
    cyc(OSC_DIV);
    axi_rd(ADDR_STATUS);
    check("ocs_short", rd[STAT_FLT_LSB + 1], 1'b0);
    @(posedge clk_sys);
    mv <= 25;
    cyc(5 * OSC_DIV);
    axi_rd(ADDR_STATUS);
    check("ocs_latch", rd[STAT_FLT_LSB + 1 -: 2], 2'b10);
    check("ocs_gates", {high_gate, low_gate}, 2'b00);
    @(posedge clk_sys);
    mv <= 0;
    restart();
    axi_rd(ADDR_STATUS);
    check("ocs_clear", rd[STAT_FLT_LSB + 1], 1'b0);
    $display("test overcurrent done");
    // Phase lock inside and outside the window
    @(posedge clk_sys);
    lper <= 200;
    cyc(1000);
    axi_rd(ADDR_STATUS);
    check("lock_in", rd[STAT_LK_BIT], 1'b1);
    @(posedge clk_sys);
    lper <= 300;
    cyc(1500);
    axi_rd(ADDR_STATUS);
    check("lock_out", rd[STAT_LK_BIT], 1'b0);
    $display("test lock done");
    end_sim();
  end
endmodule
`default_nettype wire
